/* File: pofs_consts.svh */
/*
  constants for the pulse output status flag block.
  assumes inclusion by bare name from the package and modules.
*/
`ifndef POFS_CONSTS_SVH
`define POFS_CONSTS_SVH
`define POFS_NUM_CH      4
`define POFS_ERR_W       16
`define POFS_PV_W        32
`define POFS_ERR_NONE    16'h0000
`define POFS_PV_ORIGIN   32'h0000_0000
`endif

/* File: pofs_pkg.sv */
/*
  types for the pulse output status flag block.
  assumes the constants header sits in the same folder.
*/
`include "pofs_consts.svh"
package pofs_pkg;
  typedef logic [`POFS_NUM_CH-1:0] pofs_chvec_t;
  typedef logic [`POFS_ERR_W-1:0]  pofs_err_t;
  typedef enum logic [1:0]
  {
    POFS_IDLE = 2'b01,
    POFS_RUN  = 2'b10
  } pofs_state_t;
endpackage

/* File: pofs_channel.sv */
/*
  one channel of pulse output status flags.
  assumes all event inputs are single-cycle pulses on core_clk.
*/
`timescale 1ns/10ps
`include "pofs_consts.svh"
module pofs_channel
  import pofs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  opChange,
  input  wire logic                  setPulseCount,
  input  wire logic                  outStart,
  input  wire logic                  outStop,
  input  wire logic                  countDone,
  input  wire logic                  outReset,
  input  wire logic                  searchStart,
  input  wire logic                  searchDone,
  input  wire logic                  searchFatal,
  input  wire logic                  limitClear,
  input  wire logic                  pvOverflow,
  input  wire logic                  pvWrite,
  input  wire logic [`POFS_PV_W-1:0] presentValue,
  output logic                       amountSet,
  output logic                       outCompleted,
  output logic                       outInProgress,
  output logic                       noOrigin,
  output logic                       atOrigin,
  output logic                       stopError
);
  typedef struct packed {
    pofs_state_t st;
    logic        amtSet;
    logic        done;
    logic        busy;
    logic        noOrg;
    logic        atOrg;
    logic        stopErr;
    logic        pendDone;
  } pofs_ch_t;

  pofs_ch_t stateReg;
  pofs_ch_t stateNext;

  always_comb
  begin
    stateNext = stateReg;
    case (stateReg.st)
      POFS_IDLE:
      begin
        if (outStart)
        begin
          stateNext.st = POFS_RUN;
          stateNext.busy = 1'b1;
          stateNext.done = 1'b0;
          stateNext.pendDone = 1'b0;
        end
      end
      POFS_RUN:
      begin
        if (countDone)
          stateNext.pendDone = 1'b1;
        if (outStop)
        begin
          stateNext.st = POFS_IDLE;
          stateNext.busy = 1'b0;
          stateNext.done = stateReg.pendDone | countDone;
          stateNext.amtSet = 1'b0;
        end
      end
      default: stateNext.st = POFS_IDLE;
    endcase
    if (setPulseCount)
      stateNext.amtSet = 1'b1;
    if (searchDone | pvWrite)
      stateNext.noOrg = 1'b0;
    if (outReset | searchStart | limitClear | pvOverflow)
      stateNext.noOrg = 1'b1;
    stateNext.atOrg = (presentValue == `POFS_PV_ORIGIN);
    if (searchStart)
      stateNext.stopErr = 1'b0;
    if (searchFatal)
      stateNext.stopErr = 1'b1;
    if (opChange)
    begin
      stateNext.st = POFS_IDLE;
      stateNext.amtSet = 1'b0;
      stateNext.done = 1'b0;
      stateNext.busy = 1'b0;
      stateNext.pendDone = 1'b0;
      stateNext.noOrg = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      stateReg <= '{st: POFS_IDLE, amtSet: 1'b0, done: 1'b0, busy: 1'b0,
                    noOrg: 1'b1, atOrg: 1'b1, stopErr: 1'b0, pendDone: 1'b0};
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign amountSet     = stateReg.amtSet;
  assign outCompleted  = stateReg.done;
  assign outInProgress = stateReg.busy;
  assign noOrigin      = stateReg.noOrg;
  assign atOrigin      = stateReg.atOrg;
  assign stopError     = stateReg.stopErr;
endmodule

/* File: pofs_top.sv */
/*
  four-channel pulse output status flags with shared stop error word.
  assumes event inputs are one-cycle pulses from logic on core_clk.
*/
`timescale 1ns/10ps
`include "pofs_consts.svh"
module pofs_top
  import pofs_pkg::*;
#(
  parameter int NUM_CH = `POFS_NUM_CH
)
(
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           opChange,
  input  wire logic [NUM_CH-1:0]              setPulseCount,
  input  wire logic [NUM_CH-1:0]              outStart,
  input  wire logic [NUM_CH-1:0]              outStop,
  input  wire logic [NUM_CH-1:0]              countDone,
  input  wire logic [NUM_CH-1:0]              outReset,
  input  wire logic [NUM_CH-1:0]              searchStart,
  input  wire logic [NUM_CH-1:0]              searchDone,
  input  wire logic [NUM_CH-1:0]              searchFatal,
  input  wire logic [NUM_CH-1:0]              limitClear,
  input  wire logic [NUM_CH-1:0]              pvOverflow,
  input  wire logic [NUM_CH-1:0]              pvWrite,
  input  wire logic [NUM_CH*`POFS_PV_W-1:0]   presentValue,
  input  wire logic [`POFS_ERR_W-1:0]         fatalCode,
  output logic      [NUM_CH-1:0]              amountSet,
  output logic      [NUM_CH-1:0]              outCompleted,
  output logic      [NUM_CH-1:0]              outInProgress,
  output logic      [NUM_CH-1:0]              noOrigin,
  output logic      [NUM_CH-1:0]              atOrigin,
  output logic      [NUM_CH-1:0]              stopError,
  output logic      [`POFS_ERR_W-1:0]         stopErrorCode
);
  import pofs_pkg::*;

  typedef struct packed {
    logic [`POFS_ERR_W-1:0] code;
  } pofs_top_t;

  pofs_top_t topReg;
  pofs_top_t topNext;

  // per-channel flag logic, no write path from program
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    pofs_channel u_ch (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .opChange      (opChange),
      .setPulseCount (setPulseCount[i]),
      .outStart      (outStart[i]),
      .outStop       (outStop[i]),
      .countDone     (countDone[i]),
      .outReset      (outReset[i]),
      .searchStart   (searchStart[i]),
      .searchDone    (searchDone[i]),
      .searchFatal   (searchFatal[i]),
      .limitClear    (limitClear[i]),
      .pvOverflow    (pvOverflow[i]),
      .pvWrite       (pvWrite[i]),
      .presentValue  (presentValue[i*`POFS_PV_W +: `POFS_PV_W]),
      .amountSet     (amountSet[i]),
      .outCompleted  (outCompleted[i]),
      .outInProgress (outInProgress[i]),
      .noOrigin      (noOrigin[i]),
      .atOrigin      (atOrigin[i]),
      .stopError     (stopError[i])
    );
  end

  // shared stop error word
  always_comb
  begin
    topNext = topReg;
    if (|searchFatal)
      topNext.code = fatalCode;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      topReg <= '{code: `POFS_ERR_NONE};
    else
      topReg <= topNext;
  end

  assign stopErrorCode = topReg.code;

  a_busy_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
    (outStart[0] && !outInProgress[0] && !opChange) |=> outInProgress[0])
    else $error("in-progress not set after start");
  a_done_at_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    (outStart[0] && !outInProgress[0] && !opChange) |=> !outCompleted[0])
    else $error("completed flag not cleared at start");
  a_stop_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (outStop[0] && outInProgress[0] && !opChange) |=> !outInProgress[0])
    else $error("in-progress not cleared after stop");
  a_op_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    opChange |=> (amountSet == '0) && (outCompleted == '0) && (noOrigin == '1))
    else $error("operation change did not clear flags");
  a_amount_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    (setPulseCount[0] && !opChange) |=> amountSet[0])
    else $error("amount set flag missing");
  a_done_on_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    (outInProgress[0] && countDone[0] && outStop[0] && !opChange) |=> outCompleted[0])
    else $error("completed flag missing");
  a_origin_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> atOrigin[0] == ($past(presentValue[`POFS_PV_W-1:0]) == `POFS_PV_ORIGIN))
    else $error("at-origin mismatch");
  a_noorg_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    (outReset[2] || searchStart[2] || pvOverflow[2] || limitClear[2]) |=> noOrigin[2])
    else $error("no-origin not set");
  a_noorg_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (pvWrite[2] && !outReset[2] && !searchStart[2] && !limitClear[2] && !pvOverflow[2]
     && !opChange) |=> !noOrigin[2])
    else $error("no-origin not cleared");
  a_err_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    searchFatal[1] |=> stopError[1] && stopErrorCode == $past(fatalCode))
    else $error("stop error not recorded");
  a_err_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (searchStart[1] && !searchFatal[1]) |=> !stopError[1])
    else $error("stop error not cleared");
endmodule

/* File: pofs_drive_model.sv */
/*
  pulse drive model: runs one move per go pulse.
  assumes go is one-cycle and set just after core_clk rises.
*/
`timescale 1ns/10ps
module pofs_drive_model
(
  input  wire logic       core_clk,
  input  wire logic [3:0] go,
  input  wire logic       full,
  input  wire logic [3:0] gap,
  output logic      [3:0] outStart,
  output logic      [3:0] countDone,
  output logic      [3:0] outStop
);
  logic [3:0] ch;
  initial
  begin
    outStart = 4'h0;
    countDone = 4'h0;
    outStop = 4'h0;
  end
  // start, optional full count, then stop
  always @(posedge core_clk)
  begin
    if (go !== 4'h0)
    begin
      ch = go;
      #1 outStart = ch;
      @(posedge core_clk);
      #1 outStart = 4'h0;
      repeat (gap) @(posedge core_clk);
      #1 countDone = full ? ch : 4'h0;
      @(posedge core_clk);
      #1 countDone = 4'h0;
      @(posedge core_clk);
      #1 outStop = ch;
      @(posedge core_clk);
      #1 outStop = 4'h0;
    end
  end
endmodule

/* File: tb_pulse_output_status_flags.sv */
/*
  self-checking bench for the status flag block.
  assumes pofs_top and the drive model are compiled before it.
*/
`timescale 1ns/10ps
module tb_pulse_output_status_flags;
  import pofs_pkg::*;
  localparam int SPC = 0, RST = 1, SS = 2, SD = 3, SF = 4, LC = 5, OV = 6, WR = 7;
  logic         core_clk, sys_rst, opChange, full;
  logic [3:0]   ev [8];
  logic [3:0]   go, gap, oSt, oSp, cD, aS, oC, oP, nO, aO, sE;
  logic [127:0] pv;
  logic [15:0]  fc, code;
  int           fails, cmp_count;
  int           setEv [4] = '{RST, SS, LC, OV};
  pofs_top #(.NUM_CH(4)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .opChange(opChange), .setPulseCount(ev[SPC]), .outStart(oSt), .outStop(oSp),
    .countDone(cD), .outReset(ev[RST]), .searchStart(ev[SS]), .searchDone(ev[SD]),
    .searchFatal(ev[SF]), .limitClear(ev[LC]), .pvOverflow(ev[OV]), .pvWrite(ev[WR]),
    .presentValue(pv), .fatalCode(fc), .amountSet(aS), .outCompleted(oC),
    .outInProgress(oP), .noOrigin(nO), .atOrigin(aO), .stopError(sE),
    .stopErrorCode(code));
  pofs_drive_model u_drv (.core_clk(core_clk), .go(go), .full(full), .gap(gap),
    .outStart(oSt), .countDone(cD), .outStop(oSp));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task pulse(input int k, input logic [3:0] m);
    ev[k] = m;
    tick;
    ev[k] = 4'h0;
    tick;
  endtask
  task move(input logic [3:0] m, input logic f, input logic [3:0] g, input logic [3:0] done);
    int n;
    full = f;
    gap = g;
    go = m;
    tick;
    go = 4'h0;
    for (n = 0; n < 20 && (oP & m) !== m; n++) tick;
    if (n == 20)
    begin
      fails++;
      finish_test;
    end
    chk(oP & m, m);
    chk(oC & m, 4'h0);
    for (n = 0; n < 20 && (oP & m) !== 4'h0; n++) tick;
    if (n == 20)
    begin
      fails++;
      finish_test;
    end
    chk(oC, done);
    chk(aS & m, 4'h0);
    $display("move done");
  endtask
  task reset_test;
    sys_rst = 1'b1;
    opChange = 1'b0;
    full = 1'b0;
    go = 4'h0;
    gap = 4'h1;
    pv = '0;
    fc = 16'h0000;
    foreach (ev[i]) ev[i] = 4'h0;
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk({aS, oC, oP, sE}, 16'h0000);
    chk({nO, aO, code[7:0]}, 16'hFF00);
    $display("reset done");
  endtask
  task output_test;
    pulse(SPC, 4'h1);
    chk(aS, 4'h1);
    move(4'h1, 1'b1, 4'h1, 4'h1);
    move(4'h2, 1'b0, 4'h6, 4'h1);
    move(4'h1, 1'b0, 4'h2, 4'h0);
    $display("output done");
  endtask
  task origin_test;
    pulse(WR, 4'h4);
    chk(nO, 4'hB);
    foreach (setEv[i])
    begin
      pulse(WR, 4'h4);
      pulse(setEv[i], 4'h4);
      chk(nO, 4'hF);
    end
    pulse(SD, 4'h4);
    chk(nO, 4'hB);
    $display("origin done");
  endtask
  task at_origin_test;
    pv[127:96] = 32'h0000_0005;
    tick;
    chk(aO, 4'h7);
    pv[127:96] = 32'h0000_0000;
    tick;
    chk(aO, 4'hF);
    $display("at origin done");
  endtask
  task stop_error_test;
    fc = 16'hA5C3;
    pulse(SF, 4'h2);
    chk(sE, 4'h2);
    chk(code, 16'hA5C3);
    pulse(SS, 4'h2);
    chk(sE, 4'h0);
    $display("stop error done");
  endtask
  task op_change_test;
    pulse(SPC, 4'h8);
    pulse(WR, 4'h8);
    opChange = 1'b1;
    tick;
    opChange = 1'b0;
    tick;
    chk({aS, oC, oP, nO}, 16'h000F);
    $display("op change done");
  endtask
  initial
  begin
    fails = 0;
    cmp_count = 0;
    reset_test;
    output_test;
    origin_test;
    at_origin_test;
    stop_error_test;
    op_change_test;
    finish_test;
  end
endmodule
